// *** logic/amm_cfg.svh ***
// constants for the analogue max/min tracker
// assumes inclusion by bare name from the design file; definitions only
`ifndef AMM_CFG_SVH
`define AMM_CFG_SVH
// ----------------------------------------
// data width and limits
// ----------------------------------------
`define AMM_DATA_W      16
`define AMM_UPPER_RST   16'sh7FFF
`define AMM_LOWER_RST   16'sh8000
`define AMM_AIN_FULL    16'sh03E8
`define AMM_ZERO        16'sh0000
`endif

// *** logic/amm_pkg.sv ***
// types for the analogue max/min tracker
// assumes the constants header is compiled alongside
package amm_pkg;
    typedef enum logic [1:0] {
        AMM_MODE_MIN,
        AMM_MODE_MAX,
        AMM_MODE_SEL,
        AMM_MODE_LIVE
    } amm_mode_t;
endpackage

// *** logic/amm_tracker.sv ***
// analogue max/min tracker: one scan cycle per rising mclk edge
// holds the tracked extremes, the mode selection, the limit clamp and
// the checks that guard them
// assumes inputs are synchronous to mclk and already scaled values,
// and that the upstream block keeps each input steady for a whole scan
`timescale 1ns/100ps
`include "amm_cfg.svh"

module amm_tracker #(
    parameter int DATA_W = `AMM_DATA_W
) (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     enable_in,
    input  wire logic                     reset_on_disable,
    input  wire logic [1:0]               mode_param,
    input  wire logic                     mode_from_block,
    input  wire logic                     extreme_select_in,
    input  wire logic signed [DATA_W-1:0] analog_source_in,
    input  wire logic signed [DATA_W-1:0] upper_limit,
    input  wire logic signed [DATA_W-1:0] lower_limit,
    output logic signed [DATA_W-1:0]      analog_result_out,
    output logic signed [DATA_W-1:0]      tracked_min_out,
    output logic signed [DATA_W-1:0]      tracked_max_out
);

    // ----------------------------------------
    // scan timing
    // ----------------------------------------
    // one rising mclk edge is one program scan. at that edge an enabled
    // block folds the present source value into the stored extremes and
    // registers a result chosen from the updated extremes or, in live mode, from the source, so a new peak
    // shows at the output one scan after it was applied, never two.
    // limitation: a source that moves between scans is never seen, so a
    // spike narrower than one scan is lost; faster tracking needs a faster
    // scan, not changes here.

    // ----------------------------------------
    // min/max tracking
    // ----------------------------------------
    logic signed [DATA_W-1:0] min_reg;
    logic signed [DATA_W-1:0] max_reg;
    logic                     primed_reg;
    logic signed [DATA_W-1:0] min_next;
    logic signed [DATA_W-1:0] max_next;
    logic                     clear_now;

    // the source may be any analogue value, inputs already 0..1000
    assign clear_now = !enable_in && reset_on_disable;
    // first sample after clear seeds both, so zero never skews min or max;
    // the price is one flag bit and a wider compare path, which is cheaper
    // than asking every user to preset the extremes to the rails
    assign min_next = (!primed_reg || analog_source_in < min_reg) ?
                      analog_source_in : min_reg;
    assign max_next = (!primed_reg || analog_source_in > max_reg) ?
                      analog_source_in : max_reg;

    // extremes: cleared on reset or clearing disable, updated when enabled
    always_ff @(posedge mclk) begin
        if (sys_rst || clear_now) begin
            min_reg    <= `AMM_ZERO;
            max_reg    <= `AMM_ZERO;
            primed_reg <= 1'b0;
        end else if (enable_in) begin
            min_reg    <= min_next;
            max_reg    <= max_next;
            primed_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // result selection and clamp
    // ----------------------------------------
    amm_pkg::amm_mode_t       mode_eff;
    logic signed [DATA_W-1:0] pick;
    logic signed [DATA_W-1:0] clamped;
    logic signed [DATA_W-1:0] result_reg;

    // a mode taken from another block's value always means live pass
    assign mode_eff = mode_from_block ? amm_pkg::AMM_MODE_LIVE
                                      : amm_pkg::amm_mode_t'(mode_param);

    // selection uses freshly updated extremes, so this scan sees its own sample.
    // the select input is read as a level: a rise shows the maximum and a fall
    // the minimum from the very next result, and no edge detector is needed,
    // so no false edge can follow a reset
    always_comb begin
        case (mode_eff)
            amm_pkg::AMM_MODE_MIN:  pick = min_next;
            amm_pkg::AMM_MODE_MAX:  pick = max_next;
            amm_pkg::AMM_MODE_SEL:  pick = extreme_select_in ? max_next : min_next;
            amm_pkg::AMM_MODE_LIVE: pick = analog_source_in;
            default:                pick = analog_source_in;
        endcase
    end

    logic signed [DATA_W-1:0] upper_cut;

    // upper cut first, lower applied last: if limits cross, lower wins,
    // so the result never sits below the lower limit
    assign upper_cut = (pick > upper_limit) ? upper_limit : pick;
    assign clamped   = (upper_cut < lower_limit) ? lower_limit : upper_cut;

    // result register: enabled scans load, disabled scans clear or hold
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_reg <= `AMM_ZERO;
        end else if (enable_in) begin
            result_reg <= clamped;
        end else if (reset_on_disable) begin
            result_reg <= `AMM_ZERO;
        end else begin
            result_reg <= result_reg;
        end
    end

    // data outputs straight from their registers
    assign analog_result_out = result_reg;
    assign tracked_min_out   = min_reg;
    assign tracked_max_out   = max_reg;

    // ----------------------------------------
    // checks: mode selection
    // ----------------------------------------
    // each check looks one scan later, at the registered result, and
    // compares with the values that stood at the scan that produced it
    a_min_mode_out: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && !mode_from_block && mode_param == 2'h0 |=>
        result_reg == ($past(lower_limit) > $past(upper_limit) ? $past(lower_limit) :
                       $past(min_next) < $past(lower_limit) ? $past(lower_limit) :
                       $past(min_next) > $past(upper_limit) ? $past(upper_limit) :
                       $past(min_next)))
        else $error("min mode result wrong");
    a_max_mode_out: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && !mode_from_block && mode_param == 2'h1 &&
        max_next <= upper_limit && max_next >= lower_limit |=>
        result_reg == $past(max_next))
        else $error("max mode result wrong");
    a_sel_mode_out: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && !mode_from_block && mode_param == 2'h2 && clamped == pick |=>
        result_reg == ($past(extreme_select_in) ? $past(max_next) : $past(min_next)))
        else $error("select mode result wrong");
    a_sel_rise_max: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && !mode_from_block && mode_param == 2'h2 && $rose(extreme_select_in)
        && clamped == pick |=> result_reg == $past(max_next))
        else $error("select rise not max");
    a_sel_fall_min: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && !mode_from_block && mode_param == 2'h2 && $fell(extreme_select_in)
        && clamped == pick |=> result_reg == $past(min_next))
        else $error("select fall not min");
    a_live_pass: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && (mode_from_block || mode_param == 2'h3) && clamped == pick
        |=> result_reg == $past(analog_source_in))
        else $error("live mode not passed");
    // a referenced mode always passes the source, whatever mode_param says
    a_from_block_live: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && mode_from_block && clamped == pick
        |=> result_reg == $past(analog_source_in))
        else $error("referenced mode not live");

    // ----------------------------------------
    // checks: enable handling
    // ----------------------------------------
    // a stray update in the hold case goes unseen by the bench unless the
    // source moved, so these checks watch the registers themselves
    a_disable_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        !enable_in && reset_on_disable |=> result_reg == `AMM_ZERO && min_reg == `AMM_ZERO)
        else $error("disable did not clear");
    a_disable_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !enable_in && !reset_on_disable |=> $stable(result_reg) && $stable(max_reg))
        else $error("disable did not hold");
    a_hold_min: assert property (@(posedge mclk) disable iff (sys_rst)
        !enable_in && !reset_on_disable |=> $stable(min_reg) && $stable(primed_reg))
        else $error("disable moved minimum");
    a_clear_unprime: assert property (@(posedge mclk) disable iff (sys_rst)
        clear_now |=> !primed_reg && max_reg == `AMM_ZERO)
        else $error("clear left extremes");

    // ----------------------------------------
    // checks: clamp
    // ----------------------------------------
    // crossed limits are a user error; the lower limit is the one kept
    a_clamp_low: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && lower_limit <= upper_limit |=> result_reg >= $past(lower_limit))
        else $error("result below lower limit");
    a_clamp_high: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && lower_limit <= upper_limit |=> result_reg <= $past(upper_limit))
        else $error("result above upper limit");
    a_hit_low: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && pick < lower_limit |=> result_reg == $past(lower_limit))
        else $error("low clamp not applied");
    a_hit_high: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && pick > upper_limit && lower_limit <= upper_limit
        |=> result_reg == $past(upper_limit))
        else $error("high clamp not applied");
    a_crossed_lower: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && lower_limit > upper_limit |=> result_reg == $past(lower_limit))
        else $error("crossed limits not lower");

    // ----------------------------------------
    // checks: min/max tracking
    // ----------------------------------------
    // the stored extremes are outputs too, so their updates are checked exactly
    a_track_order: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in |=> min_reg <= $past(analog_source_in) && max_reg >= $past(analog_source_in))
        else $error("extremes miss sample");
    a_seed_first: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && !primed_reg |=>
        min_reg == $past(analog_source_in) && max_reg == $past(analog_source_in))
        else $error("first sample not seeded");
    a_min_update: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && primed_reg |=>
        min_reg == ($past(analog_source_in) < $past(min_reg) ?
                    $past(analog_source_in) : $past(min_reg)))
        else $error("minimum update wrong");
    a_max_update: assert property (@(posedge mclk) disable iff (sys_rst)
        enable_in && primed_reg |=>
        max_reg == ($past(analog_source_in) > $past(max_reg) ?
                    $past(analog_source_in) : $past(max_reg)))
        else $error("maximum update wrong");
    a_min_le_max: assert property (@(posedge mclk) disable iff (sys_rst)
        min_reg <= max_reg)
        else $error("minimum above maximum");

endmodule

// *** testbench/amm_src_model.sv ***
// far-side source block feeding the tracker's analogue input
// assumes the bench supplies a random word and a source kind each cycle
`timescale 1ns/100ps

module amm_src_model (
    input  wire logic [1:0]         src_kind,
    input  wire logic signed [15:0] src_rnd,
    output logic signed [15:0]      src_out
);
    // --------------------------------------------------
    // source kinds
    // --------------------------------------------------
    // 0: scaled input, 1: flag or block value, 2+: rail extremes
    always_comb begin
        case (src_kind)
            2'h0: src_out = 16'($unsigned(src_rnd) % 16'h03E9);
            2'h1: src_out = src_rnd;
            default: src_out = src_rnd[0] ? 16'sh7FFF : 16'sh8000;
        endcase
    end
endmodule

// *** testbench/amm_tracker_tb.sv ***
// self-checking bench for the analogue max/min tracker
// assumes the constants header is on the include path
`timescale 1ns/100ps
`include "amm_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %0d got %0d", nm, e, g); end end

module amm_tracker_tb;
    logic mclk, sys_rst, enable_in, reset_on_disable, mode_from_block, extreme_select_in;
    logic [1:0]         mode_param, src_kind;
    logic signed [15:0] src_rnd, analog_source_in, upper_limit, lower_limit;
    logic signed [15:0] analog_result_out, tracked_min_out, tracked_max_out;
    logic signed [15:0] m_min, m_max, m_res, n_min, n_max;
    logic               m_primed;
    integer             seed = 32'h772e;
    int                 n_mismatch = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;
    // --------------------------------------------------
    // reference model
    // --------------------------------------------------
    // upper clamp first so that lower wins when limits cross
    function automatic logic signed [15:0] clamp(input logic signed [15:0] v);
        logic signed [15:0] t;
        t = (v > upper_limit) ? upper_limit : v;
        return (t < lower_limit) ? lower_limit : t;
    endfunction
    function automatic logic signed [15:0] pick(input logic signed [15:0] lo, hi, s);
        if (mode_from_block || mode_param == 2'h3) return s;
        if (mode_param == 2'h2) return extreme_select_in ? hi : lo;
        return (mode_param == 2'h1) ? hi : lo;
    endfunction
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
        if (sys_rst || (!enable_in && reset_on_disable)) begin
            {m_min, m_max, m_res, m_primed} = '0;
        end else if (enable_in) begin
            n_min = (!m_primed || analog_source_in < m_min) ? analog_source_in : m_min;
            n_max = (!m_primed || analog_source_in > m_max) ? analog_source_in : m_max;
            {m_min, m_max, m_primed} = {n_min, n_max, 1'b1};
            m_res = clamp(pick(n_min, n_max, analog_source_in));
        end
    end
    amm_src_model SRC (.src_kind(src_kind), .src_rnd(src_rnd), .src_out(analog_source_in));
    amm_tracker DUT (.mclk(mclk), .sys_rst(sys_rst), .enable_in(enable_in),
        .reset_on_disable(reset_on_disable), .mode_param(mode_param),
        .mode_from_block(mode_from_block), .extreme_select_in(extreme_select_in),
        .analog_source_in(analog_source_in), .upper_limit(upper_limit),
        .lower_limit(lower_limit), .analog_result_out(analog_result_out),
        .tracked_min_out(tracked_min_out), .tracked_max_out(tracked_max_out));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // --------------------------------------------------
    // stimulus: mode stretches, narrow and crossed limits, mid-run reset
    // --------------------------------------------------
    initial begin
        {sys_rst, enable_in, reset_on_disable, mode_from_block, extreme_select_in} = 5'h10;
        {mode_param, src_kind, src_rnd} = '0;
        {upper_limit, lower_limit} = {`AMM_UPPER_RST, `AMM_LOWER_RST};
        repeat (5) @(negedge mclk);
        for (int i = 0; i < 800; i++) begin
            `CHK("result", m_res, analog_result_out)
            `CHK("min", m_min, tracked_min_out)
            `CHK("max", m_max, tracked_max_out)
            sys_rst = (i == 400 || i == 401);
            enable_in = ($random(seed) & 7) != 0;
            reset_on_disable = 1'($random(seed) & 1);
            mode_param = (i < 400) ? 2'(i / 100) : 2'($random(seed) & 3);
            mode_from_block = (i >= 400) && (($random(seed) & 3) == 0);
            extreme_select_in = 1'($random(seed) & 1);
            src_kind = 2'((i >> 6) % 3);
            src_rnd = 16'($random(seed));
            upper_limit = ((i >> 5) & 1) ? 16'sh012C : `AMM_UPPER_RST;
            lower_limit = ((i >> 5) & 1) ? 16'shFF38 : `AMM_LOWER_RST;
            if (i >= 700 && i < 740) {upper_limit, lower_limit} = {16'sh0064, 16'sh01F4};
            @(negedge mclk);
        end
        tally_and_finish();
    end
endmodule
